/* File: rtl/iqd_pkg.sv */
// Constants, register map and helpers for the I/Q differential encoder.
// Assumes a 32-bit AXI4-Lite register bus and signed 16-bit I/Q levels.
package iqd_pkg;

  // ---------------------------------------------------------------
  // Sizes
  // ---------------------------------------------------------------
  localparam int IQD_AW = 8;
  localparam int IQD_SW = 4;
  localparam int IQD_LVL_W = 16;
  localparam int IQD_OFF_W = 8;
  localparam int IQD_N_MAX_DEF = 16;
  localparam int IQD_FIFO_DEPTH_DEF = 4;

  // ---------------------------------------------------------------
  // Register map (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [IQD_AW-1:0] IQD_CTRL_ADDR = 8'h00;
  localparam logic [IQD_AW-1:0] IQD_NST_ADDR = 8'h04;
  localparam logic [IQD_AW-1:0] IQD_STAT_ADDR = 8'h08;
  localparam logic [1:0] IQD_OFF_PAGE = 2'h1;
  localparam logic [1:0] IQD_MAP_PAGE = 2'h2;

  // Control bits
  localparam int IQD_CTRL_DDE = 0;
  localparam int IQD_CTRL_SDE = 1;
  localparam int IQD_CTRL_INV = 2;
  localparam int IQD_CTRL_RESTART = 3;
  localparam logic [2:0] IQD_CTRL_RST = 3'h0;

  // Number of differential states
  localparam logic [4:0] IQD_NST_RST = 5'h04;
  localparam logic [4:0] IQD_NST_MIN = 5'h02;

  // Status fields
  localparam int IQD_STAT_POS_LSB = 0;
  localparam int IQD_STAT_BPS_LSB = 8;
  localparam int IQD_STAT_PREV_BIT = 16;

  // AXI responses
  localparam logic [1:0] IQD_RESP_OKAY = 2'h0;
  localparam logic [1:0] IQD_RESP_SLVERR = 2'h2;

  // Unity level in Q2.14
  localparam logic [IQD_LVL_W-1:0] IQD_UNITY = 16'h4000;
  localparam logic [IQD_LVL_W-1:0] IQD_NEG_UNITY = 16'hc000;

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  // Default four-state map, I in [31:16], Q in [15:0]
  function automatic logic [31:0] iqd_map_rst(input int k);
    case (k)
      0: iqd_map_rst = {IQD_UNITY, IQD_UNITY};
      1: iqd_map_rst = {IQD_NEG_UNITY, IQD_UNITY};
      2: iqd_map_rst = {IQD_NEG_UNITY, IQD_NEG_UNITY};
      3: iqd_map_rst = {IQD_UNITY, IQD_NEG_UNITY};
      default: iqd_map_rst = 32'h0000_0000;
    endcase
  endfunction

  // Bits per symbol: ceiling of log2 of state count, at least one
  function automatic logic [2:0] iqd_bps(input logic [4:0] n);
    logic [2:0] b;
    b = 3'h1;
    for (int i = 1; i < 5; i++)
      if ((5'h01 << i) < n)
        b = 3'(i + 1);
    iqd_bps = b;
  endfunction

  function automatic logic [31:0] iqd_merge(input logic [31:0] old_v,
                                            input logic [31:0] new_v,
                                            input logic [3:0] strb);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++)
      if (strb[i])
        r[i*8 +: 8] = new_v[i*8 +: 8];
    iqd_merge = r;
  endfunction

endpackage

/* File: rtl/iqd_fifo.sv */
// Small synchronous FIFO for encoded I/Q words.
// Assumes one clock; clock enable low freezes every register.
`timescale 1ns/1ps
`default_nettype none
module iqd_fifo #(
  parameter int W = 64,
  parameter int D = 4
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic [W-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [W-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  localparam int PW = (D > 1) ? $clog2(D) : 1;

  if (D < 2 || W < 1)
  begin : g_chk
    $error("iqd_fifo: depth must be at least 2");
  end

  logic [W-1:0] mem_ff [D];
  logic [PW-1:0] wp_ff, nxt_wp, rp_ff, nxt_rp;
  logic [PW:0] cnt_ff, nxt_cnt;
  logic push, pop;

  assign in_ready = ce && (cnt_ff < (PW+1)'(D));
  assign out_valid = (cnt_ff != '0);
  assign out_data = mem_ff[rp_ff];

  always_comb
  begin
    push = in_valid && in_ready;
    pop = ce && out_valid && out_ready;
    nxt_wp = wp_ff;
    nxt_rp = rp_ff;
    if (push)
      nxt_wp = (wp_ff == PW'(D - 1)) ? '0 : PW'(wp_ff + 1'b1);
    if (pop)
      nxt_rp = (rp_ff == PW'(D - 1)) ? '0 : PW'(rp_ff + 1'b1);
    nxt_cnt = cnt_ff;
    if (push && !pop)
      nxt_cnt = (PW+1)'(cnt_ff + 1'b1);
    else if (pop && !push)
      nxt_cnt = (PW+1)'(cnt_ff - 1'b1);
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wp_ff <= '0;
      rp_ff <= '0;
      cnt_ff <= '0;
    end
    else if (ce)
    begin
      wp_ff <= nxt_wp;
      rp_ff <= nxt_rp;
      cnt_ff <= nxt_cnt;
    end
  end

  // Storage has no reset; it is read only when counted valid
  always_ff @(posedge clk)
  begin
    if (push)
      mem_ff[wp_ff] <= in_data;
  end
endmodule
`default_nettype wire

/* File: rtl/iqd_encoder.sv */
// I/Q differential encoder: bit-level differential data encoding,
// symbol-level differential state-map stepping and Q polarity inversion,
// with an AXI4-Lite register slave and a FIFO on the I/Q output.
// Assumes synchronous inputs on MCLK and a bit source with valid/ready.
//
// What this block does
// - Normal polarity passes I and Q with their phase relation untouched.
// - Inverted polarity negates Q, reversing rotation so I lags Q.
// - Inversion applies to both true and complementary Q outputs; I outputs are unchanged.
// - Data encoding off forwards raw bits unchanged to symbol mapping.
// - Data encoding on outputs bit i XOR bit i-1.
// - Bit-level encoding happens before I/Q mapping; encoded stream is modulated.
// - Symbol differential encoding uses a programmable signed offset table per symbol.
// - Each symbol moves the state-map position by its stored offset.
// - Offset plus one advances position by exactly one state.
// - Symbol selects a transition, not an absolute constellation point.
// - Bits per symbol equal ceiling of log2 of state count.
// - Default four-state map uses plus and minus unity for I and Q.
// - Symbol encoding starts with position at the first symbol, value 00.
// - Negative offset moves position backward by its magnitude.
// - Zero offset leaves the position unchanged.
`timescale 1ns/1ps
`default_nettype none
module iqd_encoder
  import iqd_pkg::*;
#(
  parameter int N_MAX = IQD_N_MAX_DEF,
  parameter int FIFO_DEPTH = IQD_FIFO_DEPTH_DEF
) (
  input wire logic MCLK,
  input wire logic RSTN,
  input wire logic CE,
  input wire logic [IQD_AW-1:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [IQD_AW-1:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  input wire logic DIN_BIT,
  input wire logic DIN_VALID,
  output logic DIN_READY,
  output logic [IQD_LVL_W-1:0] I_OUT,
  output logic [IQD_LVL_W-1:0] I_BAR_OUT,
  output logic [IQD_LVL_W-1:0] Q_OUT,
  output logic [IQD_LVL_W-1:0] Q_BAR_OUT,
  output logic DOUT_VALID,
  input wire logic DOUT_READY
);
  localparam int FW = 4 * IQD_LVL_W;

  // Power of two keeps every masked symbol inside the tables
  if (N_MAX < 2 || N_MAX > 16 || (N_MAX & (N_MAX - 1)) != 0)
  begin : g_chk
    $error("iqd_encoder: N_MAX must be a power of two from 2 to 16");
  end

  // ---------------------------------------------------------------
  // Register bus
  // ---------------------------------------------------------------
  logic aw_got_ff, nxt_aw_got, w_got_ff, nxt_w_got;
  logic [IQD_AW-1:0] awaddr_ff, nxt_awaddr;
  logic [31:0] wdata_ff, nxt_wdata;
  logic [3:0] wstrb_ff, nxt_wstrb;
  logic bvalid_ff, nxt_bvalid, rvalid_ff, nxt_rvalid;
  logic [1:0] bresp_ff, nxt_bresp, rresp_ff, nxt_rresp;
  logic [31:0] rdata_ff, nxt_rdata;
  logic [2:0] ctrl_ff, nxt_ctrl;
  logic [4:0] nst_ff, nxt_nst;
  logic wr_do, restart, wr_ok, rd_ok;
  logic wr_off_hit, wr_map_hit, rd_off_hit, rd_map_hit;
  logic [IQD_SW-1:0] wr_idx, rd_idx;
  logic [31:0] wr_ctrl_v, wr_nst_v, stat_v;
  logic [IQD_OFF_W-1:0] off_tab [N_MAX];
  logic [31:0] map_tab [N_MAX];

  // Stream state
  logic prev_ff, nxt_prev;
  logic [2:0] cnt_ff, nxt_cnt;
  logic [IQD_SW-1:0] sym_ff, nxt_sym, pos_ff, nxt_pos;

  assign S_AXI_AWREADY = CE && !aw_got_ff;
  assign S_AXI_WREADY = CE && !w_got_ff;
  assign S_AXI_ARREADY = CE && !rvalid_ff;
  assign S_AXI_BVALID = bvalid_ff;
  assign S_AXI_BRESP = bresp_ff;
  assign S_AXI_RVALID = rvalid_ff;
  assign S_AXI_RRESP = rresp_ff;
  assign S_AXI_RDATA = rdata_ff;

  assign wr_idx = awaddr_ff[5:2];
  assign rd_idx = S_AXI_ARADDR[5:2];
  // One bit wider, so a full sixteen-entry table is still reachable
  assign wr_off_hit = (awaddr_ff[7:6] == IQD_OFF_PAGE) && ({1'b0, wr_idx} < 5'(N_MAX));
  assign wr_map_hit = (awaddr_ff[7:6] == IQD_MAP_PAGE) && ({1'b0, wr_idx} < 5'(N_MAX));
  assign rd_off_hit = (S_AXI_ARADDR[7:6] == IQD_OFF_PAGE) && ({1'b0, rd_idx} < 5'(N_MAX));
  assign rd_map_hit = (S_AXI_ARADDR[7:6] == IQD_MAP_PAGE) && ({1'b0, rd_idx} < 5'(N_MAX));

  always_comb
  begin
    stat_v = 32'h0000_0000;
    stat_v[IQD_STAT_POS_LSB +: IQD_SW] = pos_ff;
    stat_v[IQD_STAT_BPS_LSB +: 3] = iqd_bps(nst_ff);
    stat_v[IQD_STAT_PREV_BIT] = prev_ff;
    wr_do = aw_got_ff && w_got_ff && !bvalid_ff;
    wr_ctrl_v = iqd_merge({29'h0, ctrl_ff}, wdata_ff, wstrb_ff);
    wr_nst_v = iqd_merge({27'h0, nst_ff}, wdata_ff, wstrb_ff);
    wr_ok = (awaddr_ff[7:2] == IQD_CTRL_ADDR[7:2]) || (awaddr_ff[7:2] == IQD_NST_ADDR[7:2])
            || (awaddr_ff[7:2] == IQD_STAT_ADDR[7:2]) || wr_off_hit || wr_map_hit;
    rd_ok = (S_AXI_ARADDR[7:2] == IQD_CTRL_ADDR[7:2]) || (S_AXI_ARADDR[7:2] == IQD_NST_ADDR[7:2])
            || (S_AXI_ARADDR[7:2] == IQD_STAT_ADDR[7:2]) || rd_off_hit || rd_map_hit;
    restart = wr_do && (awaddr_ff[7:2] == IQD_CTRL_ADDR[7:2]) && wr_ctrl_v[IQD_CTRL_RESTART];

    nxt_aw_got = aw_got_ff;
    nxt_awaddr = awaddr_ff;
    nxt_w_got = w_got_ff;
    nxt_wdata = wdata_ff;
    nxt_wstrb = wstrb_ff;
    nxt_bvalid = bvalid_ff;
    nxt_bresp = bresp_ff;
    nxt_rvalid = rvalid_ff;
    nxt_rresp = rresp_ff;
    nxt_rdata = rdata_ff;
    nxt_ctrl = ctrl_ff;
    nxt_nst = nst_ff;
    if (S_AXI_AWVALID && S_AXI_AWREADY)
    begin
      nxt_aw_got = 1'b1;
      nxt_awaddr = S_AXI_AWADDR;
    end
    if (S_AXI_WVALID && S_AXI_WREADY)
    begin
      nxt_w_got = 1'b1;
      nxt_wdata = S_AXI_WDATA;
      nxt_wstrb = S_AXI_WSTRB;
    end
    if (wr_do)
    begin
      nxt_aw_got = 1'b0;
      nxt_w_got = 1'b0;
      nxt_bvalid = 1'b1;
      nxt_bresp = wr_ok ? IQD_RESP_OKAY : IQD_RESP_SLVERR;
      if (awaddr_ff[7:2] == IQD_CTRL_ADDR[7:2])
        nxt_ctrl = wr_ctrl_v[2:0];
      // Out-of-range state counts are clamped, never zero
      if (awaddr_ff[7:2] == IQD_NST_ADDR[7:2])
      begin
        if (wr_nst_v < 32'(IQD_NST_MIN))
          nxt_nst = IQD_NST_MIN;
        else if (wr_nst_v > 32'(N_MAX))
          nxt_nst = 5'(N_MAX);
        else
          nxt_nst = wr_nst_v[4:0];
      end
    end
    else if (bvalid_ff && S_AXI_BREADY)
      nxt_bvalid = 1'b0;
    if (S_AXI_ARVALID && S_AXI_ARREADY)
    begin
      nxt_rvalid = 1'b1;
      nxt_rresp = rd_ok ? IQD_RESP_OKAY : IQD_RESP_SLVERR;
      nxt_rdata = 32'h0000_0000;
      if (S_AXI_ARADDR[7:2] == IQD_CTRL_ADDR[7:2])
        nxt_rdata = {29'h0, ctrl_ff};
      else if (S_AXI_ARADDR[7:2] == IQD_NST_ADDR[7:2])
        nxt_rdata = {27'h0, nst_ff};
      else if (S_AXI_ARADDR[7:2] == IQD_STAT_ADDR[7:2])
        nxt_rdata = stat_v;
      else if (rd_off_hit)
        nxt_rdata = 32'($signed(off_tab[rd_idx]));
      else if (rd_map_hit)
        nxt_rdata = map_tab[rd_idx];
    end
    else if (rvalid_ff && S_AXI_RREADY)
      nxt_rvalid = 1'b0;
  end

  always_ff @(posedge MCLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      aw_got_ff <= 1'b0;
      awaddr_ff <= '0;
      w_got_ff <= 1'b0;
      wdata_ff <= 32'h0000_0000;
      wstrb_ff <= 4'h0;
      bvalid_ff <= 1'b0;
      bresp_ff <= IQD_RESP_OKAY;
      rvalid_ff <= 1'b0;
      rresp_ff <= IQD_RESP_OKAY;
      rdata_ff <= 32'h0000_0000;
      ctrl_ff <= IQD_CTRL_RST;
      nst_ff <= IQD_NST_RST;
    end
    else if (CE)
    begin
      aw_got_ff <= nxt_aw_got;
      awaddr_ff <= nxt_awaddr;
      w_got_ff <= nxt_w_got;
      wdata_ff <= nxt_wdata;
      wstrb_ff <= nxt_wstrb;
      bvalid_ff <= nxt_bvalid;
      bresp_ff <= nxt_bresp;
      rvalid_ff <= nxt_rvalid;
      rresp_ff <= nxt_rresp;
      rdata_ff <= nxt_rdata;
      ctrl_ff <= nxt_ctrl;
      nst_ff <= nxt_nst;
    end
  end

  // ---------------------------------------------------------------
  // Offset table and I/Q state map, one entry per state
  // ---------------------------------------------------------------
  for (genvar k = 0; k < N_MAX; k++)
  begin : g_ent
    logic [IQD_OFF_W-1:0] off_ff, nxt_off;
    logic [31:0] map_ff, nxt_map;
    logic [31:0] off_w;

    always_comb
    begin
      off_w = iqd_merge(32'($signed(off_ff)), wdata_ff, wstrb_ff);
      nxt_off = off_ff;
      nxt_map = map_ff;
      if (wr_do && wr_off_hit && wr_idx == IQD_SW'(k))
        nxt_off = off_w[IQD_OFF_W-1:0];
      if (wr_do && wr_map_hit && wr_idx == IQD_SW'(k))
        nxt_map = iqd_merge(map_ff, wdata_ff, wstrb_ff);
    end

    always_ff @(posedge MCLK or negedge RSTN)
    begin
      if (!RSTN)
      begin
        off_ff <= '0;
        map_ff <= iqd_map_rst(k);
      end
      else if (CE)
      begin
        off_ff <= nxt_off;
        map_ff <= nxt_map;
      end
    end

    assign off_tab[k] = off_ff;
    assign map_tab[k] = map_ff;
  end

  // ---------------------------------------------------------------
  // Encoding data path
  // ---------------------------------------------------------------
  logic fifo_in_ready, take, last, push, enc_bit;
  logic [2:0] bps;
  logic [IQD_SW-1:0] sym_new, sym_mask, point;
  logic signed [9:0] step_sum, step_mod, n_s;
  logic [IQD_LVL_W-1:0] i_lvl, q_lvl;
  logic [FW-1:0] fifo_in, fifo_out;

  assign DIN_READY = CE && fifo_in_ready;

  always_comb
  begin
    bps = iqd_bps(nst_ff);
    sym_mask = IQD_SW'((5'h01 << bps) - 5'h01);
    take = DIN_VALID && DIN_READY;
    last = (cnt_ff == 3'(bps - 3'h1));
    // Raw bit goes straight through or as change-of-state bit
    enc_bit = ctrl_ff[IQD_CTRL_DDE] ? (DIN_BIT ^ prev_ff) : DIN_BIT;
    // Encoded bits form the symbol, so mapping sees the encoded stream
    sym_new = IQD_SW'({sym_ff, enc_bit}) & sym_mask;
    push = take && last;
    // Signed step from current position, wrapped into range
    n_s = $signed({5'h00, nst_ff});
    step_sum = $signed({6'h00, pos_ff}) + 10'($signed(off_tab[sym_new]));
    step_mod = step_sum % n_s;
    if (step_mod < 0)
      step_mod = 10'(step_mod + n_s);
    // Absolute mapping also wraps symbols beyond the state count
    if (ctrl_ff[IQD_CTRL_SDE])
      point = step_mod[IQD_SW-1:0];
    else
      point = IQD_SW'({6'h00, sym_new} % {5'h00, nst_ff});

    nxt_prev = prev_ff;
    nxt_cnt = cnt_ff;
    nxt_sym = sym_ff;
    nxt_pos = pos_ff;
    if (take)
    begin
      nxt_prev = DIN_BIT;
      nxt_cnt = last ? 3'h0 : 3'(cnt_ff + 3'h1);
      nxt_sym = last ? '0 : sym_new;
    end
    if (push && ctrl_ff[IQD_CTRL_SDE])
      nxt_pos = point;
    // Restart wins over a bit taken in the same cycle
    if (restart)
    begin
      nxt_prev = 1'b0;
      nxt_cnt = 3'h0;
      nxt_sym = '0;
      nxt_pos = '0;
    end

    i_lvl = map_tab[point][31:16];
    q_lvl = map_tab[point][15:0];
    if (ctrl_ff[IQD_CTRL_INV])
      q_lvl = IQD_LVL_W'(-q_lvl);
    // Both Q outputs derive from the same possibly inverted Q; I outputs from I
    fifo_in = {i_lvl, IQD_LVL_W'(-i_lvl), q_lvl, IQD_LVL_W'(-q_lvl)};
  end

  always_ff @(posedge MCLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      prev_ff <= 1'b0;
      cnt_ff <= 3'h0;
      sym_ff <= '0;
      pos_ff <= '0;
    end
    else if (CE)
    begin
      prev_ff <= nxt_prev;
      cnt_ff <= nxt_cnt;
      sym_ff <= nxt_sym;
      pos_ff <= nxt_pos;
    end
  end

  // ---------------------------------------------------------------
  // Output buffer; a stalled modulator back-pressures the bit source
  // ---------------------------------------------------------------
  iqd_fifo #(
    .W(FW),
    .D(FIFO_DEPTH)
  ) u_fifo (
    .clk(MCLK),
    .rst_n(RSTN),
    .ce(CE),
    .in_data(fifo_in),
    .in_valid(push),
    .in_ready(fifo_in_ready),
    .out_data(fifo_out),
    .out_valid(DOUT_VALID),
    .out_ready(DOUT_READY)
  );

  assign I_OUT = fifo_out[4*IQD_LVL_W-1 -: IQD_LVL_W];
  assign I_BAR_OUT = fifo_out[3*IQD_LVL_W-1 -: IQD_LVL_W];
  assign Q_OUT = fifo_out[2*IQD_LVL_W-1 -: IQD_LVL_W];
  assign Q_BAR_OUT = fifo_out[IQD_LVL_W-1 -: IQD_LVL_W];
endmodule
`default_nettype wire

/* File: tb/iqd_sink.sv */
// Downstream I/Q sink standing in for the modulator and output drivers.
// Assumes the tb steers stall; every accepted word is queued for the tb.
`timescale 1ns/1ps
`default_nettype none
module iqd_sink (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic stall,
  input wire logic [15:0] i_v,
  input wire logic [15:0] q_v,
  input wire logic valid,
  output logic ready
);
  logic [31:0] got[$];
  // Ready moves just after an edge, like real output logic
  always @(posedge clk or negedge rst_n)
    if (!rst_n)
      ready <= 1'b0;
    else
    begin
      ready <= !stall;
      if (valid && ready)
        got.push_back({i_v, q_v});
    end
endmodule
`default_nettype wire

/* File: tb/iqd_checker.sv */
// Concurrent checks on the encoder top ports.
// Assumes one domain on MCLK with async active-low RSTN.
`timescale 1ns/1ps
`default_nettype none
module iqd_checker (
  input wire logic MCLK,
  input wire logic RSTN,
  input wire logic CE,
  input wire logic S_AXI_AWVALID,
  input wire logic S_AXI_AWREADY,
  input wire logic S_AXI_WVALID,
  input wire logic S_AXI_WREADY,
  input wire logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic S_AXI_ARVALID,
  input wire logic S_AXI_ARREADY,
  input wire logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  input wire logic DIN_READY,
  input wire logic [15:0] I_OUT,
  input wire logic [15:0] I_BAR_OUT,
  input wire logic [15:0] Q_OUT,
  input wire logic [15:0] Q_BAR_OUT,
  input wire logic DOUT_VALID,
  input wire logic DOUT_READY
);
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RSTN);
  // ------------------------------------------------------------
  // Stream side
  // ------------------------------------------------------------
  a_ibar_neg: assert property (DOUT_VALID |-> I_BAR_OUT == 16'h0 - I_OUT)
    else $error("I bar not negated I");
  a_qbar_neg: assert property (DOUT_VALID |-> Q_BAR_OUT == 16'h0 - Q_OUT)
    else $error("Q bar not negated Q");
  a_out_hold: assert property (DOUT_VALID && !DOUT_READY |=> DOUT_VALID && $stable(I_OUT) && $stable(Q_OUT))
    else $error("word changed while stalled");
  a_ce_freeze: assert property (!CE |-> !DIN_READY && !S_AXI_AWREADY && !S_AXI_ARREADY)
    else $error("ready while disabled");
  // ------------------------------------------------------------
  // Register side
  // ------------------------------------------------------------
  a_aw_to_b: assert property ((S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY
    && !S_AXI_BVALID) ##1 CE |=> S_AXI_BVALID)
    else $error("write answer late");
  a_b_drop: assert property (CE && S_AXI_BVALID && S_AXI_BREADY |=> !S_AXI_BVALID)
    else $error("write answer repeated");
  a_ar_to_r: assert property (S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID)
    else $error("read answer late");
  a_r_drop: assert property (CE && S_AXI_RVALID && S_AXI_RREADY |=> !S_AXI_RVALID)
    else $error("read answer repeated");
  c_stall: cover property (DOUT_VALID && !DOUT_READY);
  c_full: cover property (CE && !DIN_READY);
  c_off: cover property (!CE);
endmodule
bind iqd_encoder iqd_checker u_chk (.MCLK, .RSTN, .CE, .S_AXI_AWVALID, .S_AXI_AWREADY,
  .S_AXI_WVALID, .S_AXI_WREADY, .S_AXI_BVALID, .S_AXI_BREADY, .S_AXI_ARVALID,
  .S_AXI_ARREADY, .S_AXI_RVALID, .S_AXI_RREADY, .DIN_READY, .I_OUT, .I_BAR_OUT, .Q_OUT,
  .Q_BAR_OUT, .DOUT_VALID, .DOUT_READY);
`default_nettype wire

/* File: tb/iqd_encoder_test.sv */
// Self-checking bench for the I/Q encoder.
// Assumes the sink model downstream and default 4-state map.
`timescale 1ns/1ps
`default_nettype none
module iqd_encoder_test;
  import iqd_pkg::*;
  logic mclk, rstn, ce, awv, wv, br, arv, rr, dbit, dv, dr, ov, orr, stall, rs, fs;
  logic awr, wrdy, bv, arr, rv, prev, dde, sde, inv;
  logic [7:0] awa, ara;
  logic [31:0] wd, rd, seed, d, exp_q[$];
  logic [1:0] bresp, rresp, r, acc;
  logic [15:0] io, ibo, qo, qbo, mi[4], mq[4];
  int err_count, samples_checked, off[4], pos, cnt, o;
  logic [7:0] ra[6] = '{8'h00, 8'h04, 8'h08, 8'h40, 8'h80, 8'h8c};
  logic [31:0] re[6] = '{0, 4, 32'h200, 0, {IQD_UNITY, IQD_UNITY}, {IQD_UNITY, IQD_NEG_UNITY}};
  int ns[5] = '{2, 3, 5, 8, 16};

  iqd_encoder dut (.MCLK(mclk), .RSTN(rstn), .CE(ce), .S_AXI_AWADDR(awa),
    .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr), .S_AXI_WDATA(wd), .S_AXI_WSTRB(4'hf),
    .S_AXI_WVALID(wv), .S_AXI_WREADY(wrdy), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bv),
    .S_AXI_BREADY(br), .S_AXI_ARADDR(ara), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr),
    .S_AXI_RDATA(rd), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rv), .S_AXI_RREADY(rr),
    .DIN_BIT(dbit), .DIN_VALID(dv), .DIN_READY(dr), .I_OUT(io), .I_BAR_OUT(ibo),
    .Q_OUT(qo), .Q_BAR_OUT(qbo), .DOUT_VALID(ov), .DOUT_READY(orr));
  iqd_sink sink (.clk(mclk), .rst_n(rstn), .stall(stall), .i_v(io), .q_v(qo),
    .valid(ov), .ready(orr));

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  function logic [31:0] rnd();
    seed = {seed[30:0], ^(seed & 32'h8020_0003)};
    return seed;
  endfunction
  task complete_run();
    $display("checked %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task chk(input logic [31:0] g, input logic [31:0] e, input string m);
    samples_checked++;
    if (g !== e)
    begin
      err_count++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, m, g, e);
    end
  endtask
  // Handshakes judged at negedge so comb readies have settled
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    logic ah, wh, bh;
    awa <= a;
    wd <= v;
    awv <= 1'b1;
    wv <= 1'b1;
    br <= 1'b1;
    do
    begin
      @(negedge mclk);
      ah = awv && awr;
      wh = wv && wrdy;
      bh = br && bv;
      if (bh) r = bresp;
      @(posedge mclk);
      if (ah) awv <= 1'b0;
      if (wh) wv <= 1'b0;
    end
    while (!bh);
  endtask
  task automatic rdr(input logic [7:0] a);
    logic ah, rh;
    ara <= a;
    arv <= 1'b1;
    rr <= 1'b1;
    do
    begin
      @(negedge mclk);
      ah = arv && arr;
      rh = rr && rv;
      d = rd;
      r = rresp;
      @(posedge mclk);
      if (ah) arv <= 1'b0;
    end
    while (!rh);
  endtask
  task automatic set_ctrl(input logic [2:0] c);
    wr(IQD_CTRL_ADDR, {28'h0, 1'b1, c});
    {inv, sde, dde} = c;
    pos = 0;
    prev = 1'b0;
    cnt = 0;
    acc = 2'h0;
  endtask
  // Reference: bit coding, then 2-bit symbol, then map stepping
  task automatic model_bit(input logic b);
    int k;
    acc = {acc[0], dde ? b ^ prev : b};
    prev = b;
    cnt++;
    if (cnt == 2)
    begin
      cnt = 0;
      if (sde) pos = (pos + off[acc]) & 3;
      k = sde ? pos : int'(acc);
      exp_q.push_back({mi[k], inv ? 16'h0 - mq[k] : mq[k]});
    end
  endtask
  task automatic send_bits(input logic [15:0] v, input int n);
    logic h;
    for (int i = n - 1; i >= 0; i--)
    begin
      dbit <= v[i];
      dv <= 1'b1;
      do
      begin
        @(negedge mclk);
        h = dr;
        @(posedge mclk);
      end
      while (!h);
      model_bit(v[i]);
    end
  endtask
  task automatic drain(input string m);
    int n;
    dv <= 1'b0;
    n = 0;
    while (sink.got.size() < exp_q.size() && n < 500)
    begin
      @(posedge mclk);
      n++;
    end
    chk(sink.got.size(), exp_q.size(), m);
    foreach (exp_q[i])
      if (i < sink.got.size())
        chk(sink.got[i], exp_q[i], m);
    sink.got.delete();
    exp_q.delete();
    $display("done %s", m);
  endtask
  task automatic set_off(input int k, input int v);
    wr(8'h40 + 8'(4 * k), 32'(v));
    off[k] = v;
  endtask

  // ------------------------------------------------------------
  // Clock, stall noise, watchdog
  // ------------------------------------------------------------
  initial
  begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  // Single driver: forced stall until random noise is switched on
  always @(posedge mclk)
    stall <= rs ? (rnd() % 3 == 0) : fs;
  initial
  begin
    repeat (30000) @(posedge mclk);
    err_count++;
    complete_run();
  end

  // ------------------------------------------------------------
  // Tests
  // ------------------------------------------------------------
  initial
  begin
    {rstn, ce, awv, wv, br, arv, rr, dv, dbit, fs, rs} = '0;
    {awa, ara, wd} = '0;
    seed = 32'h57f57f45;
    mi = '{IQD_UNITY, IQD_NEG_UNITY, IQD_NEG_UNITY, IQD_UNITY};
    mq = '{IQD_UNITY, IQD_UNITY, IQD_NEG_UNITY, IQD_NEG_UNITY};
    off = '{0, 0, 0, 0};
    repeat (10) @(posedge mclk);
    rstn <= 1'b1;
    repeat (3) @(posedge mclk);
    ce <= 1'b1;
    @(posedge mclk);
    foreach (ra[i])
    begin
      rdr(ra[i]);
      chk(d, re[i], "reset value");
    end
    rdr(8'hfc);
    chk(r, IQD_RESP_SLVERR, "unmapped resp");
    chk(d, 32'h0, "unmapped data");
    foreach (ns[i])
    begin
      wr(IQD_NST_ADDR, ns[i]);
      rdr(IQD_STAT_ADDR);
      chk(d[10:8], $clog2(ns[i]), "bits per symbol");
    end
    wr(IQD_NST_ADDR, 4);
    chk(r, IQD_RESP_OKAY, "write resp");
    $display("done registers");
    set_ctrl(3'h0);
    send_bits(16'h1b, 8);
    drain("plain map");
    set_ctrl(3'h4);
    send_bits(16'h1b, 8);
    drain("inverted");
    set_ctrl(3'h1);
    send_bits(16'b01010011001010, 14);
    drain("data diff");
    set_off(0, 1);
    set_off(1, -1);
    set_off(2, 2);
    set_off(3, 0);
    rdr(8'h44);
    chk(d, 32'hffff_ffff, "offset sign");
    set_ctrl(3'h2);
    send_bits(16'b0011100001, 10);
    drain("symbol diff");
    fs <= 1'b1;
    set_ctrl(3'h0);
    send_bits(16'hb4, 8);
    @(negedge mclk);
    chk(dr, 1'b0, "full fifo");
    @(posedge mclk);
    fs <= 1'b0;
    drain("fifo full");
    rs <= 1'b1;
    repeat (6)
    begin
      for (int k = 0; k < 4; k++)
      begin
        o = int'(rnd() % 7) - 3;
        set_off(k, o);
      end
      set_ctrl(3'(rnd()));
      send_bits(16'(rnd()), 16);
      drain("random");
    end
    complete_run();
  end
endmodule
`default_nettype wire
